// >>> design/stepped_gain_pkg.sv
// constants, types and helpers shared by the stepped gain controller
package stepped_gain_pkg;

    // ------------------------------------------------------------
    // clocking and tick derivation
    // ------------------------------------------------------------
    localparam int CLOCK_HZ = 25_000_000;
    localparam int BASE_OSCILLATOR_FREQ_HZ = 250_000;
    localparam int OSC_DIV = CLOCK_HZ / BASE_OSCILLATOR_FREQ_HZ;
    localparam int TICK_DIV_LOG2 = 13;
    localparam int TICK_DIV = 1 << TICK_DIV_LOG2;

    // ------------------------------------------------------------
    // repeat timing in tick periods
    // ------------------------------------------------------------
    localparam logic [3:0] FIRST_TICKS = 4'h1;
    localparam logic [3:0] SECOND_TICKS = 4'hA;
    localparam logic [3:0] REPEAT_TICKS = 4'h4;

    // ------------------------------------------------------------
    // gain index: index 0 is step 1, index 31 is step 32
    // ------------------------------------------------------------
    localparam int STEP_COUNT = 32;
    localparam logic [4:0] INDEX_MAX = 5'h1F;
    localparam logic [4:0] INDEX_MIN = 5'h00;
    localparam logic [4:0] DEFAULT_INDEX = 5'h08;
    localparam logic [5:0] DEFAULT_STEP = 6'h09;
    localparam logic signed [13:0] DEFAULT_CDB = 14'sh04B0;

    // gain table anchors in hundredths of a dB
    localparam logic signed [13:0] TOP_CDB = 14'sh0960;
    localparam logic signed [13:0] FINE_DEC_CDB = 14'sh0096;
    localparam logic signed [13:0] COARSE_TOP_CDB = -14'sh0320;
    localparam logic signed [13:0] COARSE_DEC_CDB = 14'sh00C8;
    localparam logic signed [13:0] ODD_STEP_CDB = 14'sh040C;
    localparam logic signed [13:0] MUTE_CDB = -14'sh1F40;
    localparam logic [4:0] ODD_INDEX = 5'h09;
    localparam logic [4:0] LAST_FINE_INDEX = 5'h14;
    localparam logic [4:0] FIRST_COARSE_INDEX = 5'h15;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic raise;
        logic lower;
    } request_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FIRST = 2'b01,
        ST_SECOND = 2'b10,
        ST_REPEAT = 2'b11
    } repeat_state_type;

    // saturating one-step move of the gain index
    function automatic logic [4:0] step_index(input logic [4:0] idx, input logic raise);
        logic [4:0] result;
        result = idx;
        if (raise && idx != INDEX_MIN) begin
            result = idx - 5'h01;
        end else if (!raise && idx != INDEX_MAX) begin
            result = idx + 5'h01;
        end
        return result;
    endfunction

endpackage

// >>> design/tick_divider.sv
// divides the system clock down to the slow volume tick
`timescale 1ns/10ps
`default_nettype none
module tick_divider #(
    parameter int OSC_DIV = stepped_gain_pkg::OSC_DIV,
    parameter int TICK_DIV = stepped_gain_pkg::TICK_DIV
) (
    input wire logic clock,
    input wire logic arst_n,
    output logic tick
);
    localparam int OW = (OSC_DIV > 1) ? $clog2(OSC_DIV) : 1;
    localparam int TW = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
    localparam logic [OW-1:0] OSC_LAST = OW'(OSC_DIV - 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_DIV - 1);

    logic [OW-1:0] osc_cnt;
    logic [OW-1:0] next_osc_cnt;
    logic [TW-1:0] tick_cnt;
    logic [TW-1:0] next_tick_cnt;
    logic next_tick;

    // ------------------------------------------------------------
    // oscillator rate enable, then divide by 2^13
    // ------------------------------------------------------------
    always_comb begin
        next_osc_cnt = osc_cnt + OW'(1);
        next_tick_cnt = tick_cnt;
        next_tick = 1'b0;
        if (osc_cnt == OSC_LAST) begin
            next_osc_cnt = '0;
            next_tick_cnt = tick_cnt + TW'(1);
            if (tick_cnt == TICK_LAST) begin // see R1
                next_tick_cnt = '0;
                next_tick = 1'b1;
            end
        end
    end

    // counters and tick register; tick is a one-cycle enable
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            osc_cnt <= '0;
            tick_cnt <= '0;
            tick <= 1'b0;
        end else begin
            osc_cnt <= next_osc_cnt;
            tick_cnt <= next_tick_cnt;
            tick <= next_tick;
        end
    end
endmodule // tick_divider
`default_nettype wire

// >>> design/gain_map.sv
// maps a gain index to its gain in hundredths of a dB
`timescale 1ns/10ps
`default_nettype none
module gain_map (
    input wire logic [4:0] index,
    output logic signed [13:0] gain_cdb
);
    // ------------------------------------------------------------
    // gain table
    // ------------------------------------------------------------
    function automatic logic signed [13:0] cdb_of(input logic [4:0] idx);
        logic signed [13:0] lin;
        logic signed [13:0] coarse;
        lin = stepped_gain_pkg::TOP_CDB - 14'(stepped_gain_pkg::FINE_DEC_CDB * $signed({9'h000, idx}));
        coarse = stepped_gain_pkg::COARSE_TOP_CDB
            - 14'(stepped_gain_pkg::COARSE_DEC_CDB
            * $signed({9'h000, idx - stepped_gain_pkg::FIRST_COARSE_INDEX}));
        if (idx == stepped_gain_pkg::INDEX_MAX) begin
            return stepped_gain_pkg::MUTE_CDB; // see R12
        end else if (idx == stepped_gain_pkg::ODD_INDEX) begin
            return stepped_gain_pkg::ODD_STEP_CDB; // see R10
        end else if (idx <= stepped_gain_pkg::LAST_FINE_INDEX) begin
            return lin; // see R10
        end
        return coarse; // see R11
    endfunction

    // pure lookup; the caller registers it
    always_comb begin
        gain_cdb = cdb_of(index); // see R7
    end
endmodule // gain_map
`default_nettype wire

// >>> design/stepped_gain_control.sv
// push-button stepped gain controller with auto-repeat
//
// Function
// R1 - volume tick is the 250 kHz oscillator rate divided by 2^13.
// R2 - raise and lower requests are active low on their inputs.
// R3 - a request held low for one tick moves the index one step.
// R4 - still held, the second step comes ten ticks after the first.
// R5 - still held after that, one step every four ticks.
// R6 - with both requests high the index does not change.
// R7 - thirty-two gain settings, +24 dB at step 1 to -80 dB at 32.
// R8 - power-up loads step 9, which is 12 dB.
// R9 - chip-off keeps the stored index; operation resumes on that step.
// R10 - steps 1 to 17 fall 1.5 dB each from 24 dB; step 10 is 10.36.
// R11 - steps 18-21 are -1.5 to -6 dB; 22-31 are -8 to -26 in 2 dB.
// R12 - step 32 is a near-mute setting of -80 dB.
// R13 - chip-off is active low; the outside holds it high to run.
// R14 - chip-off pin pulls down, so an undriven pin means off.
// R15 - the index saturates at step 1 and at step 32.
// R16 - both requests low gives no step; timing restarts from one request.
// R17 - requests are sampled on the tick; release resets the repeat timing.
`timescale 1ns/10ps
`default_nettype none
module stepped_gain_control #(
    parameter int OSC_DIV = stepped_gain_pkg::OSC_DIV,
    parameter int TICK_DIV = stepped_gain_pkg::TICK_DIV
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic raise_n,
    input wire logic lower_n,
    input wire logic chip_off_n,
    input wire logic chip_off_driven,
    output logic amp_on,
    output logic [5:0] gain_step,
    output logic signed [13:0] gain_cdb,
    output logic step_strobe
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic tick;
    stepped_gain_pkg::request_type req;
    stepped_gain_pkg::repeat_state_type state;
    stepped_gain_pkg::repeat_state_type next_state;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic dir_raise;
    logic next_dir_raise;
    logic [4:0] index;
    logic [4:0] next_index;
    logic next_amp_on;
    logic [5:0] next_gain_step;
    logic signed [13:0] map_cdb;
    logic next_step_strobe;
    logic single_req;

    // ------------------------------------------------------------
    // slow tick and gain lookup
    // ------------------------------------------------------------
    tick_divider #(
        .OSC_DIV(OSC_DIV),
        .TICK_DIV(TICK_DIV)
    ) u_tick (
        .clock(clock),
        .arst_n(arst_n),
        .tick(tick)
    );

    // lookup runs on the next index so gain_cdb lines up with gain_step
    gain_map u_map (
        .index(next_index),
        .gain_cdb(map_cdb)
    );

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    // low on a pin means asserted
    always_comb begin
        req.raise = ~raise_n; // see R2
        req.lower = ~lower_n; // see R2
        single_req = req.raise ^ req.lower; // see R16
    end

    // ------------------------------------------------------------
    // repeat machine and gain index
    // ------------------------------------------------------------
    // with amp_on high, state only moves on tick, so pin bounce faster than a tick is unseen
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_dir_raise = dir_raise;
        next_index = index;
        next_step_strobe = 1'b0;
        // undriven pin reads as off through the pull-down
        next_amp_on = chip_off_driven & chip_off_n; // see R13, R14
        if (!amp_on) begin
            // index is left alone while off; timing starts fresh on wake
            next_state = stepped_gain_pkg::ST_IDLE; // see R9
            next_cnt = 4'h0;
        end else if (tick) begin // see R17
            unique case (state)
                stepped_gain_pkg::ST_IDLE: begin
                    if (single_req) begin
                        next_state = stepped_gain_pkg::ST_FIRST;
                        next_cnt = stepped_gain_pkg::FIRST_TICKS; // see R3
                        next_dir_raise = req.raise;
                    end
                end
                stepped_gain_pkg::ST_FIRST,
                stepped_gain_pkg::ST_SECOND,
                stepped_gain_pkg::ST_REPEAT: begin
                    if (!single_req) begin
                        // release or both low: no step, timing restarts
                        next_state = stepped_gain_pkg::ST_IDLE; // see R6, R16, R17
                        next_cnt = 4'h0;
                    end else if (req.raise != dir_raise) begin
                        // the other button alone counts as a fresh press
                        next_state = stepped_gain_pkg::ST_FIRST; // see R16
                        next_cnt = stepped_gain_pkg::FIRST_TICKS;
                        next_dir_raise = req.raise;
                    end else if (cnt == 4'h1) begin
                        next_index = stepped_gain_pkg::step_index(index, dir_raise); // see R3, R15
                        next_step_strobe = (next_index != index);
                        if (state == stepped_gain_pkg::ST_FIRST) begin
                            next_state = stepped_gain_pkg::ST_SECOND;
                            next_cnt = stepped_gain_pkg::SECOND_TICKS; // see R4
                        end else begin
                            next_state = stepped_gain_pkg::ST_REPEAT;
                            next_cnt = stepped_gain_pkg::REPEAT_TICKS; // see R5
                        end
                    end else begin
                        next_cnt = cnt - 4'h1;
                    end
                end
            endcase
        end
        next_gain_step = {1'b0, next_index} + 6'h01;
    end

    // power-up loads the default step; nothing else resets the index
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= stepped_gain_pkg::ST_IDLE;
            cnt <= 4'h0;
            dir_raise <= 1'b0;
            index <= stepped_gain_pkg::DEFAULT_INDEX; // see R8
            amp_on <= 1'b0;
            gain_step <= stepped_gain_pkg::DEFAULT_STEP;
            gain_cdb <= stepped_gain_pkg::DEFAULT_CDB;
            step_strobe <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            dir_raise <= next_dir_raise;
            index <= next_index;
            amp_on <= next_amp_on;
            gain_step <= next_gain_step;
            gain_cdb <= map_cdb;
            step_strobe <= next_step_strobe;
        end
    end

    // ------------------------------------------------------------
    // checking helpers
    // ------------------------------------------------------------
    logic [31:0] since_tick;
    logic seen_tick;
    logic up_cycle;
    localparam logic [31:0] TICK_PERIOD_LAST = 32'(OSC_DIV * TICK_DIV - 1);

    // cycles since the last tick, for the period check
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            since_tick <= 32'h0;
            seen_tick <= 1'b0;
            up_cycle <= 1'b0;
        end else begin
            since_tick <= tick ? 32'h0 : since_tick + 32'h1;
            seen_tick <= seen_tick | tick;
            up_cycle <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_live_tick;
        tick && amp_on;
    endsequence

    sequence s_press;
        s_live_tick ##0 (state == stepped_gain_pkg::ST_IDLE) && single_req;
    endsequence

    sequence s_step_due(stepped_gain_pkg::repeat_state_type st);
        s_live_tick ##0 (state == st) && single_req && (req.raise == dir_raise) && (cnt == 4'h1);
    endsequence

    property p_tick_period;
        @(posedge clock) disable iff (!arst_n)
        tick && seen_tick |-> since_tick == TICK_PERIOD_LAST;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick period wrong"); // see R1

    property p_press_arms;
        @(posedge clock) disable iff (!arst_n)
        s_press |=> (state == stepped_gain_pkg::ST_FIRST) && (cnt == 4'h1) && $stable(index);
    endproperty
    a_press_arms: assert property (p_press_arms) else $error("press did not arm"); // see R3

    property p_first_step;
        @(posedge clock) disable iff (!arst_n)
        s_step_due(stepped_gain_pkg::ST_FIRST) |=>
            (index == stepped_gain_pkg::step_index($past(index), dir_raise))
            && (state == stepped_gain_pkg::ST_SECOND) && (cnt == 4'hA);
    endproperty
    a_first_step: assert property (p_first_step) else $error("first step or second gap wrong"); // see R4

    property p_repeat_step;
        @(posedge clock) disable iff (!arst_n)
        s_step_due(stepped_gain_pkg::ST_SECOND) or s_step_due(stepped_gain_pkg::ST_REPEAT) |=>
            (state == stepped_gain_pkg::ST_REPEAT) && (cnt == 4'h4);
    endproperty
    a_repeat_step: assert property (p_repeat_step) else $error("repeat gap wrong"); // see R5

    property p_idle_hold;
        @(posedge clock) disable iff (!arst_n)
        !(tick && amp_on && single_req) |=> $stable(index);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("index moved without one request"); // see R6

    property p_both_low;
        @(posedge clock) disable iff (!arst_n)
        s_live_tick ##0 (req.raise && req.lower) |=> (state == stepped_gain_pkg::ST_IDLE) && $stable(index);
    endproperty
    a_both_low: assert property (p_both_low) else $error("both low not ignored"); // see R16

    property p_release;
        @(posedge clock) disable iff (!arst_n)
        s_live_tick ##0 !req.raise && !req.lower |=> state == stepped_gain_pkg::ST_IDLE;
    endproperty
    a_release: assert property (p_release) else $error("release kept timing"); // see R17

    property p_off_holds;
        @(posedge clock) disable iff (!arst_n)
        !amp_on |=> $stable(index) && $stable(gain_step);
    endproperty
    a_off_holds: assert property (p_off_holds) else $error("index moved while off"); // see R9

    property p_pull_down;
        @(posedge clock) disable iff (!arst_n)
        !chip_off_driven |=> !amp_on;
    endproperty
    a_pull_down: assert property (p_pull_down) else $error("undriven pin did not turn off"); // see R14

    property p_power_up;
        @(posedge clock) disable iff (!arst_n)
        !up_cycle |-> (gain_step == 6'h09) && (gain_cdb == 14'sh04B0);
    endproperty
    a_power_up: assert property (p_power_up) else $error("power-up gain not step 9"); // see R8

    property p_saturate;
        @(posedge clock) disable iff (!arst_n)
        (index == 5'h00 |=> index inside {5'h00, 5'h01}) and (index == 5'h1F |=> index inside {5'h1E, 5'h1F});
    endproperty
    a_saturate: assert property (p_saturate) else $error("index wrapped"); // see R15

    property p_table;
        @(posedge clock) disable iff (!arst_n)
        (gain_step == 6'h01 |-> gain_cdb == 14'sh0960) and (gain_step == 6'h0A |-> gain_cdb == 14'sh040C)
        and (gain_step == 6'h11 |-> gain_cdb == 14'sh0000) and (gain_step == 6'h15 |-> gain_cdb == -14'sh0258)
        and (gain_step == 6'h16 |-> gain_cdb == -14'sh0320) and (gain_step == 6'h1F |-> gain_cdb == -14'sh0A28);
    endproperty
    a_table: assert property (p_table) else $error("gain table point wrong"); // see R7, R10, R11

    property p_mute;
        @(posedge clock) disable iff (!arst_n)
        gain_step == 6'h20 |-> gain_cdb == -14'sh1F40;
    endproperty
    a_mute: assert property (p_mute) else $error("step 32 not -80 dB"); // see R12

    property p_strobe_moves;
        @(posedge clock) disable iff (!arst_n)
        step_strobe |-> (gain_step != $past(gain_step)) && $past(tick);
    endproperty
    a_strobe_moves: assert property (p_strobe_moves) else $error("strobe without a step"); // see R3

    property p_step_range;
        @(posedge clock) disable iff (!arst_n)
        (gain_step >= 6'h01) && (gain_step <= 6'h20);
    endproperty
    a_step_range: assert property (p_step_range) else $error("step outside 1 to 32"); // see R7

    property p_amp_follows;
        @(posedge clock) disable iff (!arst_n)
        chip_off_driven && chip_off_n |=> amp_on;
    endproperty
    a_amp_follows: assert property (p_amp_follows) else $error("amp did not wake"); // see R13

    property p_tick_paced;
        @(posedge clock) disable iff (!arst_n)
        $changed(index) |-> $past(tick && amp_on);
    endproperty
    a_tick_paced: assert property (p_tick_paced) else $error("index moved off a tick"); // see R17

endmodule // stepped_gain_control
`default_nettype wire

// >>> verification/volume_buttons.sv
// push-button panel model driving the gain controller's request and chip-off pins
`timescale 1ns/10ps
`default_nettype none
module volume_buttons (
    input wire logic want_raise,
    input wire logic want_lower,
    input wire logic want_on,
    input wire logic want_drive,
    output logic raise_n,
    output logic lower_n,
    output logic chip_off_n,
    output logic chip_off_driven
);
    // ------------------------------------------------------------
    // pin levels
    // ------------------------------------------------------------
    // a pressed button pulls its line low
    assign raise_n = !want_raise;
    assign lower_n = !want_lower;
    // an undriven chip-off pin sits at the pull-down level, never the last value
    assign chip_off_n = want_drive ? want_on : 1'b0;
    assign chip_off_driven = want_drive;
endmodule // volume_buttons
`default_nettype wire

// >>> verification/stepped_gain_control_tb.sv
// self-checking testbench for the stepped gain controller
`timescale 1ns/10ps
`default_nettype none
module stepped_gain_control_tb;
    // small divider values keep the run short: one tick every 8 clocks
    localparam int P = 8;
    localparam int LIMIT = 20000;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic want_raise = 1'b0;
    logic want_lower = 1'b0;
    logic want_on = 1'b1;
    logic want_drive = 1'b1;
    wire logic raise_n;
    wire logic lower_n;
    wire logic chip_off_n;
    wire logic chip_off_driven;
    logic amp_on;
    logic [5:0] gain_step;
    logic signed [13:0] gain_cdb;
    logic step_strobe;
    logic [5:0] prev_step = 6'h09;
    int last_dir = -1;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    int n;
    int seed_val;
    logic [5:0] held;

    volume_buttons partner (.want_raise(want_raise), .want_lower(want_lower), .want_on(want_on),
        .want_drive(want_drive), .raise_n(raise_n), .lower_n(lower_n), .chip_off_n(chip_off_n),
        .chip_off_driven(chip_off_driven));

    stepped_gain_control #(.OSC_DIV(2), .TICK_DIV(4)) dut (.clock(clock), .arst_n(arst_n),
        .raise_n(raise_n), .lower_n(lower_n), .chip_off_n(chip_off_n), .chip_off_driven(chip_off_driven),
        .amp_on(amp_on), .gain_step(gain_step), .gain_cdb(gain_cdb), .step_strobe(step_strobe));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    always #20 clock = ~clock;

    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask

    // expected gain in hundredths of a dB for a step 1..32
    function automatic logic signed [13:0] gain_of(input int s);
        int v;
        if (s <= 17) v = (s == 10) ? 1036 : 2400 - 150 * (s - 1);
        else if (s <= 21) v = -150 * (s - 17);
        else if (s <= 31) v = -800 - 200 * (s - 22);
        else v = -8000;
        return 14'(v);
    endfunction

    // wait cycles after the current edge, then change the buttons
    task automatic set_btn(input logic r, input logic l, input int gap);
        repeat (gap) @(posedge clock);
        #1;
        want_raise = r;
        want_lower = l;
        if (r != l) last_dir = r ? -1 : 1;
    endtask

    // cycles until the next strobe, -1 if none within the limit
    task automatic wait_strobe(input int limit, output int cnt);
        cnt = 0;
        do begin
            @(negedge clock);
            cnt++;
        end while (step_strobe !== 1'b1 && cnt < limit);
        if (step_strobe !== 1'b1) cnt = -1;
    endtask

    task automatic quiet(input int c, input string msg);
        int k;
        for (k = 0; k < c; k++) begin
            @(negedge clock);
            if (step_strobe !== 1'b0) check(1'b0, msg);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d, errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // monitor: every strobe moves one step the held way, table always holds
    // ------------------------------------------------------------
    always @(negedge clock) begin
        if (arst_n) begin
            if (step_strobe === 1'b1) begin
                check(gain_step === ((last_dir > 0) ? prev_step + 6'h01 : prev_step - 6'h01), "bad step");
            end else begin
                check(gain_step === prev_step, "step without strobe");
            end
            check(gain_cdb === gain_of(int'(gain_step)), "gain table");
            prev_step <= gain_step;
        end
    end

    // hang guard
    always @(posedge clock) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_total++;
            $display("Error at %0t: timeout", $time);
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed_val = $urandom(61);
        repeat (2) @(posedge clock);
        #1;
        check(gain_step === 6'h09 && gain_cdb === 14'sh04B0, "power-up step");
        check(amp_on === 1'b0 && step_strobe === 1'b0, "reset outputs");
        arst_n = 1'b1;
        repeat (2) @(negedge clock);
        check(amp_on === 1'b1, "amp not on");
        quiet(5 * P, "idle strobe");
        // hold raise: 1 tick, then 10, then every 4, up to step 1
        set_btn(1'b1, 1'b0, 1);
        wait_strobe(2 * P + 3, n);
        check(n >= P && gain_step === 6'h08, "first raise");
        wait_strobe(10 * P + 2, n);
        check(n == 10 * P, "second step spacing");
        repeat (6) begin
            wait_strobe(4 * P + 2, n);
            check(n == 4 * P, "repeat spacing");
        end
        check(gain_step === 6'h01 && gain_cdb === 14'sh0960, "top step");
        quiet(10 * P, "raise past top");
        // sweep down through the whole table to step 32
        set_btn(1'b0, 1'b1, 3);
        repeat (31) begin
            wait_strobe(10 * P + 3, n);
            check(n > 0, "lower sweep stalled");
        end
        check(gain_step === 6'h20 && gain_cdb === -14'sh1F40, "mute step");
        quiet(12 * P, "lower past bottom");
        // both held: nothing; then raise alone restarts from a fresh press
        set_btn(1'b1, 1'b1, 1);
        quiet(10 * P, "both held");
        set_btn(1'b1, 1'b0, 1);
        wait_strobe(2 * P + 3, n);
        check(n >= P && gain_step === 6'h1F, "restart after both");
        set_btn(1'b0, 1'b0, 1);
        quiet(5 * P, "released");
        // chip off with raise held keeps the index
        held = gain_step;
        set_btn(1'b1, 1'b0, 3);
        want_on = 1'b0;
        repeat (2) @(negedge clock);
        check(amp_on === 1'b0, "amp still on");
        quiet(10 * P, "step while off");
        @(posedge clock);
        #1;
        want_on = 1'b1;
        repeat (2) @(negedge clock);
        check(amp_on === 1'b1 && gain_step === held, "index lost");
        set_btn(1'b0, 1'b0, 1);
        // floating chip-off pin means off
        want_drive = 1'b0;
        repeat (2) @(negedge clock);
        check(amp_on === 1'b0, "floating pin on");
        @(posedge clock);
        #1;
        want_drive = 1'b1;
        // random taps and holds; the monitor judges every step
        repeat (40) begin
            case ($urandom_range(0, 2))
                0: set_btn(1'b1, 1'b0, 3);
                1: set_btn(1'b0, 1'b1, 3);
                default: set_btn(1'b1, 1'b1, 3);
            endcase
            repeat ($urandom_range(1, 8 * P)) @(posedge clock);
            set_btn(1'b0, 1'b0, 0);
            repeat ($urandom_range(3, 3 * P)) @(posedge clock);
        end
        repeat (2) @(negedge clock);
        report_and_stop();
    end
endmodule // stepped_gain_control_tb
`default_nettype wire
